// ==== pscc_cpu_model.sv ====
// Purpose: behavioural cpu core and interrupt controller facing the block
// Assumes: runs on clk_sys beside the block
// Notes: prefetch queue fills fill_dly+2 cycles after halt_exec rises
`timescale 1ns/1ps
`default_nettype none
module pscc_cpu_model
  import pscc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // bench commands
  input wire logic do_halt,
  input wire logic [3:0] fill_dly,
  input wire pscc_wake_t req,
  // block side
  input wire logic [2:0] mode,
  output logic halt_exec,
  output logic prefetch_full,
  output pscc_wake_t wake
);
  logic [3:0] fill_q;
  logic filling_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      halt_exec <= 1'b0;
      prefetch_full <= 1'b0;
      fill_q <= 4'h0;
      filling_q <= 1'b0;
      wake <= '0;
    end else begin
      halt_exec <= do_halt;
      wake <= req;
      if (halt_exec) begin
        filling_q <= 1'b1;
        fill_q <= fill_dly;
      end else if (filling_q && fill_q != 4'h0) begin
        fill_q <= fill_q - 4'h1;
      end else if (filling_q) begin
        // fetching goes on after the halt until the queue is full
        prefetch_full <= 1'b1;
        filling_q <= 1'b0;
      end
      // a running cpu drains its queue again
      if (mode == 3'h0 && !halt_exec && !filling_q) begin
        prefetch_full <= 1'b0;
      end
    end
  end
endmodule // pscc_cpu_model
`default_nettype wire

// ==== pscc_pkg.sv ====
// Purpose: shared constants and types of the power-save clock controller
// Assumes: byte-wide registers reached over a plain strobe port
// Notes: addresses are full byte addresses
package pscc_pkg;

  // register addresses
  localparam logic [31:0] PSCC_OSC_SETTLE_TIME_SELECT_ADDR = 32'hfffff380;
  localparam logic [31:0] PSCC_CLOCK_OUT_MODE_REG_ADDR = 32'hfffff38a;
  localparam logic [31:0] PSCC_PSC_ADDR = 32'hfffff1f0;
  localparam logic [31:0] PSCC_PROTECT_COMMAND_REG_ADDR = 32'hfffff1f4;
  localparam logic [31:0] PSCC_STAT_ADDR = 32'hfffff3f0;

  // values after reset
  localparam logic [7:0] PSCC_OSC_SETTLE_TIME_SELECT_RST = 8'h04;
  localparam logic [7:0] PSCC_CLOCK_OUT_MODE_REG_RST = 8'h00;
  localparam logic [7:0] PSCC_PSC_RST = 8'h00;

  // field positions
  localparam int PSCC_CLOCK_OUT_MODE_REG_EN_BIT = 4;
  localparam int PSCC_CLOCK_OUT_MODE_REG_DIV_HI_BIT = 1;
  localparam int PSCC_CLOCK_OUT_MODE_REG_DIV_LO_BIT = 0;
  localparam int PSCC_PSC_WATCH_BIT = 1;
  localparam int PSCC_PSC_STOP_BIT = 2;

  // settle-time codes
  localparam logic [2:0] PSCC_SETTLE_E10 = 3'h0;
  localparam logic [2:0] PSCC_SETTLE_E12 = 3'h1;
  localparam logic [2:0] PSCC_SETTLE_E13 = 3'h2;
  localparam logic [2:0] PSCC_SETTLE_E14 = 3'h3;
  localparam logic [2:0] PSCC_SETTLE_E15 = 3'h4;

  // wait counter width, wide enough for 2^15 periods
  localparam int PSCC_CNT_W = 16;

  typedef enum logic [2:0] {
    PSCC_ST_NORM,
    PSCC_ST_DRAIN,
    PSCC_ST_HALT,
    PSCC_ST_WATCH,
    PSCC_ST_STOP,
    PSCC_ST_OSC_TB,
    PSCC_ST_SETTLE
  } pscc_state_t;

  // wake requests from the interrupt controller
  typedef struct packed {
    logic nmi;
    logic irq;
    logic irq_above;
    logic int_en;
  } pscc_wake_t;

  // clock and power enables
  typedef struct packed {
    logic cpu;
    logic periph;
    logic watch;
    logic osc;
    logic pll;
    logic flash;
  } pscc_gate_t;

endpackage

// ==== pscc_top.sv ====
// Purpose: clock output, settle wait and power-save mode sequencing
// Assumes: cpu and interrupt controller run on clk_sys
// Notes: reset returns everything to normal mode, as a plain system reset
`timescale 1ns/1ps
`default_nettype none
module pscc_top
  import pscc_pkg::*;
#(
  parameter logic [15:0] SETTLE_CYC_E10 = 16'h0400,
  parameter logic [15:0] SETTLE_CYC_E12 = 16'h1000,
  parameter logic [15:0] SETTLE_CYC_E13 = 16'h2000,
  parameter logic [15:0] SETTLE_CYC_E14 = 16'h4000,
  parameter logic [15:0] SETTLE_CYC_E15 = 16'h8000,
  parameter logic [15:0] TB_WAIT_CYC = 16'h0400
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // cpu side
  input wire logic halt_exec,
  input wire logic prefetch_full,
  output logic cpu_hold,
  // interrupt controller side
  input wire pscc_wake_t wake,
  output logic wake_ack,
  // clock and power enables
  output pscc_gate_t gate,
  output logic [2:0] mode,
  // pin
  output logic clock_out_pin
);

  pscc_state_t st_q, st_d;
  logic [7:0] osc_settle_time_select_q, clock_out_mode_reg_q, psc_q, rdata_q;
  logic prot_armed_q, pin_q, ack_q, hold_q;
  logic [3:0] div_q;
  pscc_gate_t gate_q, gate_d;
  logic [15:0] settle_len_q;
  logic tmr_load, tmr_busy, tmr_done;
  logic [15:0] tmr_val;

  function automatic logic [15:0] settle_len(input logic [2:0] code);
    case (code)
      PSCC_SETTLE_E10: settle_len = SETTLE_CYC_E10;
      PSCC_SETTLE_E12: settle_len = SETTLE_CYC_E12;
      PSCC_SETTLE_E13: settle_len = SETTLE_CYC_E13;
      PSCC_SETTLE_E14: settle_len = SETTLE_CYC_E14;
      // prohibited codes fall back to the longest, safest wait
      default: settle_len = SETTLE_CYC_E15;
    endcase
  endfunction

  // register decode
  wire logic wr_osc_settle_time_select = reg_wr && (reg_addr == PSCC_OSC_SETTLE_TIME_SELECT_ADDR);
  wire logic wr_clock_out_mode_reg = reg_wr && (reg_addr == PSCC_CLOCK_OUT_MODE_REG_ADDR);
  wire logic wr_psc = reg_wr && (reg_addr == PSCC_PSC_ADDR);
  wire logic wr_protect_command_reg = reg_wr && (reg_addr == PSCC_PROTECT_COMMAND_REG_ADDR);
  wire logic psc_ok = wr_psc && prot_armed_q;
  wire logic [7:0] clock_out_mode_reg_mask = 8'h13;

  wire logic clock_out_mode_reg_en = clock_out_mode_reg_q[PSCC_CLOCK_OUT_MODE_REG_EN_BIT];
  wire logic [1:0] div_sel = {clock_out_mode_reg_q[PSCC_CLOCK_OUT_MODE_REG_DIV_HI_BIT], clock_out_mode_reg_q[PSCC_CLOCK_OUT_MODE_REG_DIV_LO_BIT]};
  wire logic req_watch = psc_q[PSCC_PSC_WATCH_BIT];
  wire logic req_stop = psc_q[PSCC_PSC_STOP_BIT];

  // wake decode: any unmasked request releases, priority only steers ack
  wire logic release_ev = wake.nmi || wake.irq;
  wire logic ack_ev = wake.nmi || (wake.irq_above && wake.int_en);
  wire logic in_sleep = (st_q == PSCC_ST_DRAIN) || (st_q == PSCC_ST_HALT) ||
                        (st_q == PSCC_ST_WATCH) || (st_q == PSCC_ST_STOP);
  wire logic rel_now = in_sleep && release_ev;
  wire logic mode_exit = rel_now && ((st_q == PSCC_ST_WATCH) || (st_q == PSCC_ST_STOP));

  // clock generator runs in these states; pin freezes elsewhere
  wire logic clk_run = (st_q == PSCC_ST_NORM) || (st_q == PSCC_ST_DRAIN) ||
                       (st_q == PSCC_ST_HALT) || (st_q == PSCC_ST_SETTLE);
  wire logic pin_d = !clock_out_mode_reg_en ? 1'b0 : (clk_run ? div_q[div_sel] : pin_q);

  // settle wait or time-base wait share one counter
  assign tmr_load = ((st_q == PSCC_ST_STOP) && release_ev) ||
                    ((st_q == PSCC_ST_WATCH) && release_ev) ||
                    ((st_q == PSCC_ST_OSC_TB) && tmr_done);
  assign tmr_val = (st_q == PSCC_ST_STOP) ? TB_WAIT_CYC : settle_len(osc_settle_time_select_q[2:0]);

  pscc_wait_cnt #(
    .W(PSCC_CNT_W)
  ) u_wait (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // mode sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      PSCC_ST_NORM: begin
        if (req_stop) begin
          st_d = PSCC_ST_STOP;
        end else if (req_watch) begin
          st_d = PSCC_ST_WATCH;
        end else if (halt_exec) begin
          st_d = PSCC_ST_DRAIN;
        end
      end
      PSCC_ST_DRAIN: begin
        if (release_ev) begin
          st_d = PSCC_ST_NORM;
        end else if (prefetch_full) begin
          st_d = PSCC_ST_HALT;
        end
      end
      PSCC_ST_HALT: begin
        if (release_ev) begin
          st_d = PSCC_ST_NORM;
        end
      end
      PSCC_ST_WATCH: begin
        if (release_ev) begin
          st_d = PSCC_ST_SETTLE;
        end
      end
      PSCC_ST_STOP: begin
        if (release_ev) begin
          st_d = PSCC_ST_OSC_TB;
        end
      end
      PSCC_ST_OSC_TB: begin
        if (tmr_done) begin
          st_d = PSCC_ST_SETTLE;
        end
      end
      PSCC_ST_SETTLE: begin
        if (tmr_done) begin
          st_d = PSCC_ST_NORM;
        end
      end
      default: st_d = PSCC_ST_NORM;
    endcase
  end

  // clock and power enables per mode
  always_comb begin
    gate_d = '0;
    case (st_d)
      PSCC_ST_NORM, PSCC_ST_DRAIN: gate_d = '1;
      PSCC_ST_HALT: begin
        gate_d = '1;
        gate_d.cpu = 1'b0;
      end
      PSCC_ST_WATCH: begin
        gate_d.watch = 1'b1;
        gate_d.osc = 1'b1;
        gate_d.flash = 1'b0;
      end
      PSCC_ST_STOP: gate_d = '0;
      PSCC_ST_OSC_TB: gate_d.osc = 1'b1;
      PSCC_ST_SETTLE: begin
        // peripherals and flash come back while the cpu still waits
        gate_d = '1;
        gate_d.cpu = 1'b0;
      end
      default: gate_d = '1;
    endcase
  end

  // register read mux, reserved bits read as zero
  wire logic [7:0] rd_mux =
    (reg_addr == PSCC_OSC_SETTLE_TIME_SELECT_ADDR) ? osc_settle_time_select_q :
    (reg_addr == PSCC_CLOCK_OUT_MODE_REG_ADDR) ? clock_out_mode_reg_q :
    (reg_addr == PSCC_PSC_ADDR) ? psc_q :
    (reg_addr == PSCC_STAT_ADDR) ? {5'h00, st_q} : 8'h00;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= PSCC_ST_NORM;
      gate_q <= '1;
      hold_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      st_q <= st_d;
      gate_q <= gate_d;
      hold_q <= (st_d == PSCC_ST_OSC_TB) || (st_d == PSCC_ST_SETTLE);
      ack_q <= rel_now && ack_ev;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      osc_settle_time_select_q <= PSCC_OSC_SETTLE_TIME_SELECT_RST;
      clock_out_mode_reg_q <= PSCC_CLOCK_OUT_MODE_REG_RST;
      prot_armed_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (wr_osc_settle_time_select) begin
        osc_settle_time_select_q <= {5'h00, reg_wdata[2:0]};
      end
      if (wr_clock_out_mode_reg) begin
        clock_out_mode_reg_q <= reg_wdata & clock_out_mode_reg_mask;
      end
      // only a write disarms, so reads between the two stores do no harm
      if (reg_wr) begin
        prot_armed_q <= wr_protect_command_reg;
      end
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // a protected write in the release cycle wins over the self-clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      psc_q <= PSCC_PSC_RST;
    end else if (psc_ok) begin
      psc_q <= reg_wdata & 8'h06;
    end else if (mode_exit) begin
      psc_q <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 4'h0;
      pin_q <= 1'b0;
      settle_len_q <= 16'h0000;
    end else begin
      if (clk_run) begin
        div_q <= div_q + 4'h1;
      end
      pin_q <= pin_d;
      if (tmr_load) begin
        settle_len_q <= tmr_val;
      end
    end
  end

  // cpu registers, ram and io lines are never touched here
  assign reg_rdata = rdata_q;
  assign cpu_hold = hold_q;
  assign wake_ack = ack_q;
  assign gate = gate_q;
  assign mode = st_q;
  assign clock_out_pin = pin_q;

  // checking logic
  logic [15:0] settle_run_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      settle_run_q <= 16'h0000;
    end else begin
      settle_run_q <= (st_q == PSCC_ST_SETTLE) ? settle_run_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_stop_release;
    (st_q == PSCC_ST_STOP) && release_ev ##1 (st_q == PSCC_ST_OSC_TB);
  endsequence

  sequence s_settle_end;
    (st_q == PSCC_ST_SETTLE) ##1 (st_q == PSCC_ST_NORM);
  endsequence

  sequence s_watch_release;
    (st_q == PSCC_ST_WATCH) && release_ev ##1 (st_q == PSCC_ST_SETTLE);
  endsequence

  AST_PIN_LOW: assert property (!clock_out_mode_reg_en |=> !clock_out_pin)
    else $error("clock-out pin not low while disabled");
  AST_PIN_DIV: assert property (clock_out_mode_reg_en && clk_run |=>
      clock_out_pin == $past(div_q[div_sel]))
    else $error("clock-out pin does not follow selected divider tap");
  AST_PIN_FREEZE: assert property (clock_out_mode_reg_en && !clk_run |=> $stable(clock_out_pin))
    else $error("clock-out pin moved while the clock generator was stopped");
  AST_SETTLE_LEN: assert property (s_settle_end |->
      $past(settle_run_q) + 16'h0001 == settle_len_q)
    else $error("settle wait length differs from selected code");
  AST_SETTLE_HOLD: assert property (st_q == PSCC_ST_SETTLE |-> cpu_hold && !gate.cpu)
    else $error("cpu released during settle wait");
  AST_SETTLE_BUSY: assert property (st_q == PSCC_ST_SETTLE |-> tmr_busy)
    else $error("settle state without a running wait");
  AST_WATCH_REL: assert property (s_watch_release |-> cpu_hold && tmr_busy)
    else $error("watch release did not start the settle wait");
  AST_STOP_TB: assert property (s_stop_release |-> ##1 (st_q != PSCC_ST_NORM))
    else $error("stop release skipped the time-base wait");
  AST_HALT_GATE: assert property (st_q == PSCC_ST_HALT |->
      !gate.cpu && gate.periph && gate.pll)
    else $error("halt gating wrong");
  AST_WATCH_GATE: assert property (st_q == PSCC_ST_WATCH |->
      gate.watch && !gate.periph && !gate.flash && !gate.pll)
    else $error("watch gating wrong");
  AST_STOP_GATE: assert property (st_q == PSCC_ST_STOP |->
      !gate.osc && !gate.watch && !gate.cpu)
    else $error("stop gating wrong");
  AST_DRAIN: assert property (st_q == PSCC_ST_DRAIN && !prefetch_full && !release_ev |=>
      st_q == PSCC_ST_DRAIN && gate.cpu)
    else $error("cpu stopped before prefetch queue full");
  AST_HALT_EXIT: assert property (st_q == PSCC_ST_HALT && wake.irq |=>
      st_q == PSCC_ST_NORM)
    else $error("unmasked interrupt did not end halt");
  AST_ACK_HIGH: assert property (rel_now && ack_ev |=> wake_ack)
    else $error("higher-priority request not acknowledged with the release");
  AST_NO_ACK_LOW: assert property (rel_now && !wake.nmi && !wake.irq_above |=> !wake_ack)
    else $error("lower-priority request acknowledged");
  AST_PROTECT: assert property (wr_psc && !prot_armed_q && !mode_exit |=> $stable(psc_q))
    else $error("unprotected power-save write took effect");
  AST_SELF_CLR: assert property (mode_exit && !psc_ok |=> psc_q == 8'h00)
    else $error("request bits not cleared on release");

endmodule // pscc_top
`default_nettype wire

// ==== pscc_wait_cnt.sv ====
// Purpose: down counter that times the oscillator and settle waits
// Assumes: load_val is at least one
// Notes: done is high in the last of load_val busy cycles
`timescale 1ns/1ps
`default_nettype none
module pscc_wait_cnt #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic at_one = (cnt_q == W'(1));

  assign busy = (cnt_q != '0);
  assign done = at_one;
  assign cnt_d = load ? load_val : (busy ? cnt_q - W'(1) : cnt_q);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // pscc_wait_cnt
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench of the power-save clock controller
// Assumes: waits shortened through the top parameters
// Notes: random wake kinds and prefetch delays, settle codes 1 to 4 in turn
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pscc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic do_halt = 1'b0;
  logic [3:0] fill_dly = '0;
  pscc_wake_t req = '0;
  logic [7:0] reg_rdata;
  logic halt_exec, prefetch_full, cpu_hold, wake_ack, clock_out_pin;
  pscc_wake_t wake;
  pscc_gate_t gate;
  logic [2:0] mode;
  int n_fail = 0;
  int checks = 0;
  int acks = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;
  pscc_top #(.SETTLE_CYC_E12(16'h0005), .SETTLE_CYC_E13(16'h0007), .SETTLE_CYC_E14(16'h0009),
    .SETTLE_CYC_E15(16'h000b), .TB_WAIT_CYC(16'h0006)) pscc_top_inst (
    .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .halt_exec,
    .prefetch_full, .cpu_hold, .wake, .wake_ack, .gate, .mode, .clock_out_pin);
  pscc_cpu_model pscc_cpu_model_inst (.clk_sys, .sys_rst, .do_halt, .fill_dly, .req, .mode,
    .halt_exec, .prefetch_full, .wake);
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hung wait ends the run as a failure
  always @(posedge clk_sys) begin
    cyc++;
    if (wake_ack === 1'b1) acks++;
    if (cyc > 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  task automatic prot_wr(input logic [7:0] d);
    wr(PSCC_PROTECT_COMMAND_REG_ADDR, 8'h00);
    wr(PSCC_PSC_ADDR, d);
  endtask
  // counts drain cycles on the way, for the prefetch check
  task automatic wait_mode(input logic [2:0] m, output int n1);
    n1 = 0;
    for (int i = 0; i < 200 && mode !== m; i++) begin
      tick();
      if (mode === 3'h1) n1++;
    end
    chk("mode", {13'h0, m}, {13'h0, mode});
  endtask
  function automatic pscc_wake_t kind(input int k);
    case (k)
      0: return 4'b1000;
      1: return 4'b0100;
      2: return 4'b0111;
      default: return 4'b0110;
    endcase
  endfunction
  function automatic int settle_n(input int code);
    case (code)
      // the shortest code keeps its full count
      0: return 1024;
      1: return 5;
      2: return 7;
      3: return 9;
      default: return 11;
    endcase
  endfunction
  task automatic wake_up(input pscc_wake_t w, input int n_tb, input int n_set);
    int n5, n6, nh, a0;
    n5 = 0;
    n6 = 0;
    nh = 0;
    a0 = acks;
    @(posedge clk_sys);
    req <= w;
    for (int i = 0; i < 300 && mode !== 3'h0; i++) begin
      tick();
      if (mode === 3'h5) n5++;
      if (mode === 3'h6) n6++;
      if (cpu_hold === 1'b1) nh++;
    end
    repeat (2) tick();
    chk("tb_wait", 16'(n_tb), 16'(n5));
    chk("settle", 16'(n_set), 16'(n6));
    chk("cpu_hold", 16'(n_tb + n_set), 16'(nh));
    chk("ack", {15'h0, w.nmi | (w.irq_above & w.int_en)}, 16'(acks - a0));
    @(posedge clk_sys);
    req <= '0;
  endtask
  initial begin
    int hi, p, t0, n, code;
    logic prev;
    pscc_wake_t w;
    void'($urandom(32'hf1cdd071));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(PSCC_OSC_SETTLE_TIME_SELECT_ADDR, PSCC_OSC_SETTLE_TIME_SELECT_RST, "osc_settle_time_select_rst");
    rd(PSCC_CLOCK_OUT_MODE_REG_ADDR, PSCC_CLOCK_OUT_MODE_REG_RST, "clock_out_mode_reg_rst");
    rd(PSCC_PSC_ADDR, PSCC_PSC_RST, "psc_rst");
    rd(32'hfffff3fc, 8'h00, "unmapped");
    wr(PSCC_PSC_ADDR, 8'h02);
    rd(PSCC_PSC_ADDR, 8'h00, "psc_unprot");
    for (int d = 0; d < 4; d++) begin
      wr(PSCC_CLOCK_OUT_MODE_REG_ADDR, 8'h00);
      wr(PSCC_CLOCK_OUT_MODE_REG_ADDR, 8'(d));
      hi = 0;
      repeat (20) begin
        tick();
        if (clock_out_pin !== 1'b0) hi++;
      end
      chk("pin_off", 16'h0, 16'(hi));
      wr(PSCC_CLOCK_OUT_MODE_REG_ADDR, 8'h10 | 8'(d));
      rd(PSCC_CLOCK_OUT_MODE_REG_ADDR, 8'h10 | 8'(d), "clock_out_mode_reg");
      p = -1;
      t0 = -1;
      for (int i = 0; i < 60; i++) begin
        prev = clock_out_pin;
        tick();
        if (prev === 1'b0 && clock_out_pin === 1'b1) begin
          if (t0 >= 0 && p < 0) p = i - t0;
          t0 = i;
        end
      end
      chk("pin_period", 16'(2 << d), 16'(p));
    end
    for (code = 1; code < 5; code++) begin
      wr(PSCC_OSC_SETTLE_TIME_SELECT_ADDR, 8'(code));
      prot_wr(8'h02);
      wait_mode(3'h3, n);
      chk("gate_watch", 16'h000c, {10'h0, gate});
      rd(PSCC_PSC_ADDR, 8'h02, "psc_watch");
      wake_up(kind($urandom_range(0, 3)), 0, settle_n(code));
      rd(PSCC_PSC_ADDR, 8'h00, "psc_clear");
    end
    wr(PSCC_OSC_SETTLE_TIME_SELECT_ADDR, 8'h04);
    prot_wr(8'h04);
    wait_mode(3'h4, n);
    chk("gate_stop", 16'h0000, {10'h0, gate});
    wake_up(kind($urandom_range(0, 3)), 6, 11);
    rd(PSCC_PSC_ADDR, 8'h00, "psc_clear");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys);
      fill_dly <= 4'($urandom_range(0, 5));
      do_halt <= 1'b1;
      @(posedge clk_sys);
      do_halt <= 1'b0;
      wait_mode(3'h2, n);
      chk("drain", 16'(fill_dly + 2), 16'(n));
      chk("gate_halt", 16'h001f, {10'h0, gate});
      w = kind(k);
      wake_up(w, 0, 0);
    end
    stop_test();
  end
endmodule // testbench
`default_nettype wire
